// ==== rtl/sme_buffer.sv ====
`timescale 1ns/1ps
module sme_buffer
    import sme_pkg::*;
#(
    parameter int WIDTH = BYTE_BITS,
    parameter int DEPTH = RX_BUF_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_o = (count_reg != CNT_FULL);
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
    endfunction

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            if (push && !pop) count_reg <= CNT_W'(count_reg + 1'b1);
            else if (pop && !push) count_reg <= CNT_W'(count_reg - 1'b1);
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_mem
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) mem_reg[i] <= '0;
                else if (push && wr_ptr_reg == PTR_W'(i)) mem_reg[i] <= in_data_i;
            end
        end
    endgenerate
endmodule // sme_buffer

// ==== rtl/sme_engine.sv ====
`timescale 1ns/1ps
module sme_engine
    import sme_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ctrl_wr_i,
    input wire sme_ctrl_type ctrl_i,
    output sme_ctrl_type ctrl_o,
    input wire logic data_wr_i,
    input wire logic [7:0] data_wr_byte_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire sme_flags_type flags_clr_i,
    output sme_flags_type flags_o,
    input wire logic irq_en_i,
    output logic irq_o,
    output logic busy_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic nss_i,
    output logic nss_o,
    output logic nss_oe_n_o,
    output logic nss_route_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_BITS-1:0] pin_lvl;
    logic sck_lvl;
    logic mosi_lvl;
    logic miso_lvl;
    logic nss_lvl;

    sme_sync #(
        .WIDTH(SYNC_BITS),
        .RESET_VAL(SYNC_RESET)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({sck_i, mosi_i, miso_i, nss_i}),
        .level_o(pin_lvl)
    );

    assign {sck_lvl, mosi_lvl, miso_lvl, nss_lvl} = pin_lvl;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sme_ctrl_type ctrl_reg;
    sme_ctrl_type ctrl_next;
    sme_flags_type flags_reg;
    sme_flags_type flags_set;
    sme_state_type state_reg;
    sme_state_type state_next;
    logic [3:0] half_cnt_reg;
    logic [4:0] edge_cnt_reg;
    logic sck_act_reg;
    logic [7:0] shift_reg;
    logic shift_full_reg;
    logic [7:0] tx_buf_reg;
    logic tx_full_reg;
    logic [2:0] bit_cnt_reg;
    logic sck_prev_reg;
    logic nss_prev_reg;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic is_master;
    logic is_slave;
    logic sel_3w;
    logic sel_4w_in;
    logic slave_sel;
    logic mode_fault;
    logic nss_fall;
    logic load;

    assign is_master = ctrl_reg.engine_en & ctrl_reg.master_en;
    assign is_slave = ctrl_reg.engine_en & ~ctrl_reg.master_en;
    assign sel_3w = (ctrl_reg.sel_mode == SEL_3WIRE);
    assign sel_4w_in = (ctrl_reg.sel_mode == SEL_4WIRE_IN);
    assign slave_sel = is_slave & (sel_3w | (sel_4w_in & ~nss_lvl));
    assign mode_fault = is_master & sel_4w_in & ~nss_lvl;
    assign nss_fall = is_slave & sel_4w_in & nss_prev_reg & ~nss_lvl;

    // ------------------------------------------------------------
    // Slave clock edges
    // ------------------------------------------------------------
    logic s_act_now;
    logic s_act_prev;
    logic s_lead;
    logic s_trail;
    logic s_sample;
    logic s_done;

    assign s_act_now = sck_lvl ^ ctrl_reg.clk_polarity;
    assign s_act_prev = sck_prev_reg ^ ctrl_reg.clk_polarity;
    assign s_lead = slave_sel & s_act_now & ~s_act_prev;
    assign s_trail = slave_sel & ~s_act_now & s_act_prev;
    assign s_sample = ctrl_reg.clk_phase ? s_trail : s_lead;
    assign s_done = s_sample & (bit_cnt_reg == LAST_BIT);

    // ------------------------------------------------------------
    // Master clock generation
    // ------------------------------------------------------------
    logic m_tick;
    logic m_edge;
    logic [4:0] m_edge_idx;
    logic m_sample;
    logic m_last;
    logic m_launch;
    logic mosi_reg;

    assign m_tick = (state_reg != ST_IDLE) & (half_cnt_reg == SCK_HALF_CYCLES - 4'h1);
    assign m_edge = m_tick & ((state_reg == ST_SETUP) |
        ((state_reg == ST_SHIFT) & (edge_cnt_reg != LAST_EDGE)));
    assign m_edge_idx = (state_reg == ST_SETUP) ? 5'h00 : 5'(edge_cnt_reg + 5'h01);
    assign m_sample = m_edge & (m_edge_idx[0] == ctrl_reg.clk_phase);
    assign m_last = m_edge & (m_edge_idx == LAST_EDGE);
    assign m_launch = m_edge & ~m_sample;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (load && is_master) state_next = ST_SETUP;
            ST_SETUP: if (m_tick) state_next = ST_SHIFT;
            ST_SHIFT: if (m_tick && edge_cnt_reg == LAST_EDGE) state_next = ST_END;
            ST_END: if (m_tick) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        if (!is_master) state_next = ST_IDLE;
    end

    // ------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------
    logic in_bit;
    logic [7:0] sh_in;
    logic shift_en;
    logic byte_done;
    logic [7:0] rx_byte;
    logic rx_in_ready;
    logic wr_accept;

    assign in_bit = is_master ? miso_lvl : mosi_lvl;
    assign sh_in = {shift_reg[6:0], in_bit};
    assign shift_en = m_sample | s_sample;
    assign load = tx_full_reg & ~shift_full_reg &
        (is_master ? (state_reg == ST_IDLE) : ((bit_cnt_reg == 3'h0) & ~s_sample));
    assign byte_done = m_last | s_done;
    assign rx_byte = (m_last & ~m_sample) ? shift_reg : sh_in;
    assign wr_accept = data_wr_i & ~tx_full_reg;

    sme_buffer #(
        .WIDTH(BYTE_BITS),
        .DEPTH(RX_BUF_DEPTH)
    ) u_rx_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(byte_done),
        .in_ready_o(rx_in_ready),
        .in_data_i(rx_byte),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );

    // ------------------------------------------------------------
    // Control and flags
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_wr_i ? ctrl_i : ctrl_reg;
        if (mode_fault) begin
            ctrl_next.master_en = 1'b0;
            ctrl_next.engine_en = 1'b0;
        end
    end

    assign flags_set.xfer_done_flag = byte_done;
    assign flags_set.write_collision_flag = data_wr_i & tx_full_reg;
    assign flags_set.mode_fault_flag = mode_fault;
    assign flags_set.rx_overrun_flag = s_done & ~rx_in_ready;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
            flags_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            flags_reg <= (flags_reg & ~flags_clr_i) | flags_set;
        end
    end

    // ------------------------------------------------------------
    // Master sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            half_cnt_reg <= 4'h0;
            edge_cnt_reg <= 5'h00;
            sck_act_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            half_cnt_reg <= (m_tick || state_reg == ST_IDLE) ? 4'h0 : 4'(half_cnt_reg + 4'h1);
            if (state_reg == ST_IDLE) edge_cnt_reg <= 5'h00;
            else if (m_edge) edge_cnt_reg <= m_edge_idx;
            if (!is_master) sck_act_reg <= 1'b0;
            else if (m_edge) sck_act_reg <= ~sck_act_reg;
        end
    end

    // ------------------------------------------------------------
    // Shift register and transmit buffer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= BYTE_RESET;
            shift_full_reg <= 1'b0;
            tx_buf_reg <= BYTE_RESET;
            tx_full_reg <= 1'b0;
        end else begin
            if (load) shift_reg <= tx_buf_reg;
            else if (shift_en) shift_reg <= sh_in;
            if (!ctrl_reg.engine_en || byte_done) shift_full_reg <= 1'b0;
            else if (load) shift_full_reg <= 1'b1;
            if (wr_accept) tx_buf_reg <= data_wr_byte_i;
            if (wr_accept) tx_full_reg <= 1'b1;
            else if (load) tx_full_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Master output bit, set from the transmit buffer on load, then moved on launch edges
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mosi_reg <= 1'b0;
        end else if (load) begin
            mosi_reg <= tx_buf_reg[7];
        end else if (m_launch) begin
            mosi_reg <= shift_reg[7];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_reg <= 3'h0;
            sck_prev_reg <= 1'b0;
            nss_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_lvl;
            nss_prev_reg <= nss_lvl;
            if (!is_slave || nss_fall) bit_cnt_reg <= 3'h0;
            else if (s_sample) bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign sck_o = sck_act_reg ^ ctrl_reg.clk_polarity;
    assign sck_oe_n_o = ~is_master;
    assign mosi_o = mosi_reg;
    assign mosi_oe_n_o = ~is_master;
    assign miso_o = shift_reg[7];
    assign miso_oe_n_o = ~slave_sel;
    assign nss_o = ctrl_reg.sel_mode[0];
    assign nss_oe_n_o = ~ctrl_reg.sel_mode[1];
    assign nss_route_o = ~sel_3w;

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    assign ctrl_o = ctrl_reg;
    assign flags_o = flags_reg;
    assign irq_o = irq_en_i & (|flags_reg);
    assign busy_o = (state_reg != ST_IDLE) | (slave_sel & (bit_cnt_reg != 3'h0));
endmodule // sme_engine

// ==== rtl/sme_pkg.sv ====
package sme_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int RX_BUF_DEPTH = 2;
    localparam int SYNC_BITS = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SCK_HALF_NS = 50;
    localparam logic [3:0] SCK_HALF_CYCLES = 4'((SCK_HALF_NS + CLOCK_PERIOD_NS - 1)
        / CLOCK_PERIOD_NS);
    localparam logic [4:0] LAST_EDGE = 5'h0F;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // Select mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_3WIRE = 2'h0;
    localparam logic [1:0] SEL_4WIRE_IN = 2'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_MODE_RESET = SEL_4WIRE_IN;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] SYNC_RESET = 4'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic master_en;
        logic engine_en;
        logic [1:0] sel_mode;
        logic clk_phase;
        logic clk_polarity;
    } sme_ctrl_type;

    localparam sme_ctrl_type CTRL_RESET = '{master_en: 1'b0, engine_en: 1'b0,
        sel_mode: SEL_MODE_RESET, clk_phase: 1'b0, clk_polarity: 1'b0};

    typedef struct packed {
        logic xfer_done_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic rx_overrun_flag;
    } sme_flags_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SETUP = 2'h1,
        ST_SHIFT = 2'h3,
        ST_END = 2'h2
    } sme_state_type;

endpackage

// ==== rtl/sme_sync.sv ====
`timescale 1ns/1ps
module sme_sync
    import sme_pkg::*;
#(
    parameter int WIDTH = SYNC_BITS,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);
    // ------------------------------------------------------------
    // Three stages, level taken when stages two and three agree
    // ------------------------------------------------------------
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    assign level_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & level_reg);
    assign level_o = level_reg;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            level_reg <= RESET_VAL;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end
endmodule // sme_sync

// ==== verification/sme_engine_monitor.sv ====
`timescale 1ns/1ps
module sme_engine_chk
    import sme_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ctrl_wr_i,
    input wire sme_ctrl_type ctrl_o,
    input wire sme_flags_type flags_clr_i,
    input wire sme_flags_type flags_o,
    input wire logic irq_en_i,
    input wire logic irq_o,
    input wire logic busy_o,
    input wire logic sck_o,
    input wire logic mosi_oe_n_o,
    input wire logic miso_oe_n_o,
    input wire logic nss_i,
    input wire logic nss_o,
    input wire logic nss_oe_n_o,
    input wire logic nss_route_o
);
    // ----------------------------------------
    // Pin and flag checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_sel_dir;
        nss_oe_n_o == !ctrl_o.sel_mode[1];
    endproperty
    a_sel_dir: assert property (p_sel_dir) else $error("select pin direction wrong");
    property p_sel_level;
        ctrl_o.sel_mode[1] |-> nss_o == ctrl_o.sel_mode[0];
    endproperty
    a_sel_level: assert property (p_sel_level) else $error("select output level wrong");
    property p_route;
        nss_route_o == (ctrl_o.sel_mode != SEL_3WIRE);
    endproperty
    a_route: assert property (p_route) else $error("select pin routing wrong");
    property p_miso_off;
        !ctrl_o.engine_en |-> miso_oe_n_o;
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("miso driven while disabled");
    property p_unsel;
        (ctrl_o.engine_en && !ctrl_o.master_en && ctrl_o.sel_mode == SEL_4WIRE_IN && nss_i)[*8]
            |-> miso_oe_n_o;
    endproperty
    a_unsel: assert property (p_unsel) else $error("miso driven while unselected");
    property p_three_wire;
        ctrl_o.engine_en && !ctrl_o.master_en && ctrl_o.sel_mode == SEL_3WIRE |-> !miso_oe_n_o;
    endproperty
    a_three_wire: assert property (p_three_wire) else $error("miso released in 3-wire");
    property p_role;
        ctrl_o.engine_en |-> mosi_oe_n_o == !ctrl_o.master_en;
    endproperty
    a_role: assert property (p_role) else $error("mosi direction wrong for role");
    property p_sck_idle;
        ctrl_o.master_en && ctrl_o.engine_en && !busy_o |-> sck_o == ctrl_o.clk_polarity;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck not idle between bytes");
    property p_fault;
        $fell(ctrl_o.master_en) && !$past(ctrl_wr_i) |-> ##[0:1] flags_o.mode_fault_flag;
    endproperty
    a_fault: assert property (p_fault) else $error("master dropped without fault flag");
    property p_sticky;
        flags_o.xfer_done_flag && !flags_clr_i.xfer_done_flag |=> flags_o.xfer_done_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("done flag cleared by itself");
    property p_irq;
        irq_o == (irq_en_i && (flags_o != '0));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");
endmodule // sme_engine_chk

bind sme_engine sme_engine_chk u_chk (.clock_i, .rst_i, .ctrl_wr_i, .ctrl_o, .flags_clr_i,
    .flags_o, .irq_en_i, .irq_o, .busy_o, .sck_o, .mosi_oe_n_o, .miso_oe_n_o, .nss_i, .nss_o,
    .nss_oe_n_o, .nss_route_o);

// ==== verification/sme_engine_test.sv ====
`timescale 1ns/1ps
module sme_engine_test
    import sme_pkg::*;
;
    logic clock_i, rst_i, ctrl_wr_i, data_wr_i, rx_ready_i, irq_en_i;
    sme_ctrl_type ctrl_i, ctrl_o;
    sme_flags_type flags_clr_i, flags_o;
    logic [7:0] data_wr_byte_i, rx_data_o, far_got, mi;
    logic rx_valid_o, irq_o, busy_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, far_miso;
    logic miso_o, miso_oe_n_o, nss_o, nss_oe_n_o, nss_route_o, tb_sck, tb_mosi, tb_nss, ph;
    int fail_count, n_checks, sck_cnt;
    wire sck_line = sck_oe_n_o ? tb_sck : sck_o;
    wire mosi_line = mosi_oe_n_o ? tb_mosi : mosi_o;
    wire miso_line = miso_oe_n_o ? far_miso : miso_o;
    wire nss_line = nss_oe_n_o ? tb_nss : nss_o;

    sme_engine u_dut (.clock_i(clock_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_i(ctrl_i),
        .ctrl_o(ctrl_o), .data_wr_i(data_wr_i), .data_wr_byte_i(data_wr_byte_i),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
        .flags_clr_i(flags_clr_i), .flags_o(flags_o), .irq_en_i(irq_en_i), .irq_o(irq_o),
        .busy_o(busy_o), .sck_i(sck_line), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
        .mosi_i(mosi_line), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_line),
        .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .nss_i(nss_line), .nss_o(nss_o),
        .nss_oe_n_o(nss_oe_n_o), .nss_route_o(nss_route_o));
    sme_far_slave u_far (.rst_i(rst_i), .sel_n_i(nss_line), .sck_i(sck_line),
        .mosi_i(mosi_line), .reply_i(8'h3C), .miso_o(far_miso), .got_o(far_got));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge sck_o) sck_cnt++;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic set_ctrl(input logic m, input logic [1:0] sel, input logic pol);
        ctrl_i = '{master_en: m, engine_en: 1'b1, sel_mode: sel, clk_phase: ph,
            clk_polarity: pol};
        ctrl_wr_i = 1'b1;
        tick(1);
        ctrl_wr_i = 1'b0;
        tick(1);
    endtask
    task automatic write_byte(input logic [7:0] b);
        data_wr_byte_i = b;
        data_wr_i = 1'b1;
        tick(1);
        data_wr_i = 1'b0;
        tick(1);
    endtask
    task automatic clr_flags;
        flags_clr_i = '1;
        tick(1);
        flags_clr_i = '0;
        tick(1);
    endtask
    task automatic pop(input logic [7:0] exp);
        check("rx_valid", 8'(rx_valid_o), 8'h01);
        check("rx_data", rx_data_o, exp);
        rx_ready_i = 1'b1;
        tick(1);
        rx_ready_i = 1'b0;
        tick(1);
    endtask
    task automatic wait_done;
        int n = 0;
        while (flags_o.xfer_done_flag !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        check("done", 8'(flags_o.xfer_done_flag), 8'h01);
    endtask
    task automatic slave_frame(input logic [7:0] mo, input int nb, input logic sel);
        tb_nss = !sel;
        #200;
        for (int i = 7; i > 7 - nb; i--) begin
            tb_mosi = mo[i];
            #62.5;
            mi[i] = miso_o;
            tb_sck = 1'b1;
            #62.5;
            tb_sck = 1'b0;
        end
        tb_mosi = ~mo[0];
        #200;
        tb_nss = 1'b1;
        #100;
        tick(1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        check("ctrl", 8'(ctrl_o), 8'(CTRL_RESET));
        check("flags", 8'(flags_o), 8'h00);
        check("nss_route", 8'(nss_route_o), 8'h01);
        check("miso_oe_n", 8'(miso_oe_n_o), 8'h01);
    endtask
    task automatic t_master;
        irq_en_i = 1'b1;
        for (int lo = 1; lo >= 0; lo--) begin
            set_ctrl(1'b1, 2'(2 + lo), 1'b0);
            check("nss_o", 8'(nss_o), 8'(lo));
            check("nss_oe_n", 8'(nss_oe_n_o), 8'h00);
        end
        sck_cnt = 0;
        write_byte(8'hA5);
        tick(1);
        write_byte(8'h5A);
        write_byte(8'h0F);
        check("write_collision_flag", 8'(flags_o.write_collision_flag), 8'h01);
        wait_done;
        check("irq", 8'(irq_o), 8'h01);
        check("sck_cnt", 8'(sck_cnt), 8'h08);
        check("far_got", far_got, 8'hA5);
        clr_flags;
        wait_done;
        check("far_got", far_got, 8'h5A);
        pop(8'h3C);
        pop(8'hA5);
        tick(20);
        check("sck_cnt", 8'(sck_cnt), 8'h10);
        set_ctrl(1'b1, 2'h3, 1'b0);
        set_ctrl(1'b1, 2'h3, 1'b1);
        check("sck_idle", 8'(sck_o), 8'h01);
        clr_flags;
        ph = 1'b1;
        set_ctrl(1'b1, 2'h2, 1'b1);
        write_byte(8'hC6);
        wait_done;
        check("far_got", far_got, 8'hC6);
        set_ctrl(1'b1, 2'h3, 1'b1);
        pop(8'h5A);
        ph = 1'b0;
    endtask
    task automatic t_fault;
        set_ctrl(1'b1, SEL_4WIRE_IN, 1'b0);
        tb_nss = 1'b0;
        tick(10);
        check("ctrl", 8'(ctrl_o), 8'(CTRL_RESET));
        check("mode_fault_flag", 8'(flags_o.mode_fault_flag), 8'h01);
        check("irq", 8'(irq_o), 8'h01);
        tb_nss = 1'b1;
        tick(10);
        check("mode_fault_flag", 8'(flags_o.mode_fault_flag), 8'h01);
        clr_flags;
        check("flags", 8'(flags_o), 8'h00);
    endtask
    task automatic t_slave;
        set_ctrl(1'b0, SEL_4WIRE_IN, 1'b0);
        check("miso_oe_n", 8'(miso_oe_n_o), 8'h01);
        write_byte(8'hC3);
        slave_frame(8'hFF, 8, 1'b0);
        check("done", 8'(flags_o.xfer_done_flag), 8'h00);
        slave_frame(8'h96, 8, 1'b1);
        check("miso", mi, 8'hC3);
        check("done", 8'(flags_o.xfer_done_flag), 8'h01);
        slave_frame(8'hE7, 3, 1'b1);
        slave_frame(8'h5A, 8, 1'b1);
        slave_frame(8'h11, 8, 1'b1);
        check("ovrn", 8'(flags_o.rx_overrun_flag), 8'h01);
        pop(8'h96);
        pop(8'h5A);
        check("rx_valid", 8'(rx_valid_o), 8'h00);
        clr_flags;
    endtask
    task automatic t_three_wire;
        set_ctrl(1'b0, SEL_3WIRE, 1'b0);
        check("nss_route", 8'(nss_route_o), 8'h00);
        check("miso_oe_n", 8'(miso_oe_n_o), 8'h00);
        slave_frame(8'hE7, 3, 1'b0);
        ctrl_i.engine_en = 1'b0;
        ctrl_wr_i = 1'b1;
        tick(1);
        set_ctrl(1'b0, SEL_3WIRE, 1'b0);
        slave_frame(8'h42, 8, 1'b0);
        pop(8'h42);
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        rst_i = 1'b1;
        ctrl_wr_i = 1'b0;
        ctrl_i = CTRL_RESET;
        data_wr_i = 1'b0;
        data_wr_byte_i = 8'h00;
        rx_ready_i = 1'b0;
        flags_clr_i = '0;
        irq_en_i = 1'b0;
        tb_sck = 1'b0;
        tb_mosi = 1'b0;
        tb_nss = 1'b1;
        ph = 1'b0;
        fail_count = 0;
        n_checks = 0;
        sck_cnt = 0;
        tick(2);
        rst_i = 1'b0;
        tick(1);
        t_reset;
        t_master;
        t_fault;
        t_slave;
        t_three_wire;
        tally_and_finish;
    end
endmodule // sme_engine_test

// ==== verification/sme_far_slave.sv ====
`timescale 1ns/1ps
module sme_far_slave (
    input wire logic rst_i,
    input wire logic sel_n_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic [7:0] reply_i,
    output logic miso_o,
    output logic [7:0] got_o
);
    logic [2:0] cnt_reg;
    logic [2:0] idx_reg;
    logic [7:0] tx_reg;
    // Sample on rising edge while selected, MSB first
    always @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 3'h0;
            got_o <= 8'h00;
        end else if (!sel_n_i) begin
            cnt_reg <= cnt_reg + 3'h1;
            got_o <= {got_o[6:0], mosi_i};
        end
    end
    // Change on falling edge; echo last byte next time
    always @(negedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            idx_reg <= 3'h0;
            tx_reg <= reply_i;
        end else if (!sel_n_i) begin
            idx_reg <= cnt_reg;
            if (cnt_reg == 3'h0) begin
                tx_reg <= got_o;
            end
        end
    end
    // Released line reads high
    assign miso_o = sel_n_i ? 1'b1 : tx_reg[3'h7 - idx_reg];
endmodule // sme_far_slave
